//--- rtl/otgc_pkg.sv
package otgc_pkg;
   // ***********************************
   // timing
   // ***********************************
   localparam int unsigned CLK_HZ      = 25_000_000;
   localparam int unsigned CYC_PER_MS  = CLK_HZ / 1000;
   localparam int unsigned HICCUP_S    = 3;
   localparam int unsigned HICCUP_CYC_DEF = HICCUP_S * CLK_HZ;
   localparam int unsigned BLINK_HZ    = 1;
   localparam int unsigned BLINK_CYC_DEF  = CLK_HZ / (2 * BLINK_HZ);
   localparam int unsigned EXIT_MS     = 32;
   localparam int unsigned EXIT_CYC_DEF   = EXIT_MS * CYC_PER_MS;
   // delay tables: plain defaults in ms
   localparam int unsigned LL_DLY_MS [4] = '{1, 2, 4, 8};
   localparam int unsigned EN_DLY_MS [4] = '{1, 2, 4, 8};
   localparam int unsigned LL_DLY_CYC_DEF [4] = '{LL_DLY_MS[0] * CYC_PER_MS, LL_DLY_MS[1] * CYC_PER_MS,
                                                   LL_DLY_MS[2] * CYC_PER_MS, LL_DLY_MS[3] * CYC_PER_MS};
   localparam int unsigned EN_DLY_CYC_DEF [4] = '{EN_DLY_MS[0] * CYC_PER_MS, EN_DLY_MS[1] * CYC_PER_MS,
                                                   EN_DLY_MS[2] * CYC_PER_MS, EN_DLY_MS[3] * CYC_PER_MS};
   localparam int unsigned TMR_W       = 27;
   localparam int unsigned NSTAT_DEF   = 8;

   // ***********************************
   // reverse-power states
   // ***********************************
   typedef enum logic [2:0] {
      ST_OFF,
      ST_RESET,
      ST_SOFTSTART,
      ST_REGULATE,
      ST_LIGHT_LOAD_OFF,
      ST_OVERLOAD_RETRY
   } otgc_state_t;

   // ***********************************
   // host controller registers
   // ***********************************
   localparam int unsigned ADDR_W     = 4;
   localparam int unsigned DATA_W     = 8;
   localparam logic [3:0] OFS_CTRL    = 4'h0;
   localparam logic [3:0] OFS_CMD     = 4'h1;
   localparam logic [3:0] OFS_STATUS  = 4'h2;
   localparam logic [7:0] CTRL_RESET  = 8'h00;
   localparam int unsigned CTRL_REQ   = 0;
   localparam int unsigned CTRL_CHG   = 1;
   localparam int unsigned CTRL_ALLOW = 2;
   localparam int unsigned CTRL_HIZ   = 3;
   localparam int unsigned CTRL_THIGN = 4;
   localparam int unsigned CTRL_GPIO  = 5;
   localparam int unsigned CMD_EXIT   = 0;
   localparam int unsigned CMD_READ   = 1;
   localparam int unsigned ST_BUSY    = 0;
   localparam int unsigned ST_SEEN    = 1;
   localparam int unsigned ST_CHGN    = 2;
   localparam int unsigned ST_GPIO    = 3;
   localparam int unsigned ST_ALERTN  = 4;
endpackage

//--- rtl/otgc_link_if.sv
`timescale 1ns/1ps
interface otgc_link_if;
   logic reverse_power_request_n;
   logic charge_request;
   logic storage_exit_n;
   logic charge_status_oe_n;
   logic alert_oe_n;
   logic gpio_o;
   logic gpio_oe_n;
   // serial-bus stand-ins
   logic reverse_power_allow;
   logic high_impedance_mode;
   logic thermistor_ignore;
   logic gpio_sel;
   logic status_read;
   // resolved open-drain / two-way levels, pulled up when released
   logic charge_status_n;
   logic alert_n;
   logic comp_or_gpio_pin;
   assign charge_status_n  = charge_status_oe_n;
   assign alert_n          = alert_oe_n;
   assign comp_or_gpio_pin = gpio_oe_n ? 1'b1 : gpio_o;

   modport dev (
      input  reverse_power_request_n, charge_request, storage_exit_n,
      input  reverse_power_allow, high_impedance_mode, thermistor_ignore, gpio_sel, status_read,
      input  comp_or_gpio_pin,
      output charge_status_oe_n, alert_oe_n, gpio_o, gpio_oe_n
   );
   modport host (
      output reverse_power_request_n, charge_request, storage_exit_n,
      output reverse_power_allow, high_impedance_mode, thermistor_ignore, gpio_sel, status_read,
      input  charge_status_n, alert_n, comp_or_gpio_pin
   );
endinterface

//--- rtl/otgc_device.sv
// Implementation choices: the address map and the plain strobed port.
`timescale 1ns/1ps
// Function
// [R1] light load past delay enters light-load off
// [R2] light-load off only in buck operation
// [R3] converter disabled in light-load off
// [R4] leave light-load off only on mode exit
// [R5] output undervoltage enters overload retry
// [R6] retry end returns to reset, repeats
// [R7] request honoured only when allow bit set
// [R8] request pin polarity selectable, low default
// [R9] charge request high enables charging
// [R10] status low while charging, else released
// [R11] status blinks at one hertz on fault
// [R12] alert low on any status change
// [R13] mask bits block alert per source
// [R14] alert held until status read
// [R15] alert stays while fault persists
// [R16] storage exit pin low 32ms leaves storage
// [R17] comp pin usable as gpio when unused
// [R18] host sets thermistor ignore when unused
// [R19] reset state start delay then softstart
// [R20] light-load off only from regulation
// [R21] light-load timer restarts when load rises
// [R22] retry timer cleared on every entry
module otgc_device
   import otgc_pkg::*;
#(
   parameter int unsigned HICCUP_CYC     = HICCUP_CYC_DEF,
   parameter int unsigned BLINK_CYC      = BLINK_CYC_DEF,
   parameter int unsigned EXIT_CYC       = EXIT_CYC_DEF,
   parameter int unsigned LL_DLY_CYC [4] = LL_DLY_CYC_DEF,
   parameter int unsigned EN_DLY_CYC [4] = EN_DLY_CYC_DEF,
   parameter int unsigned NSTAT          = NSTAT_DEF
) (
   input  wire logic             clk,
   input  wire logic             sys_rst,
   otgc_link_if.dev              lnk,
   input  wire logic             req_active_high,
   input  wire logic [1:0]       light_load_delay_sel,
   input  wire logic [1:0]       reverse_start_delay_sel,
   input  wire logic             light_load,
   input  wire logic             buck_mode,
   input  wire logic             out_uv,
   input  wire logic             faults_clear,
   input  wire logic             softstart_done,
   input  wire logic             major_fault,
   input  wire logic             charging,
   input  wire logic             charge_fault,
   input  wire logic [NSTAT-1:0] status,
   input  wire logic [NSTAT-1:0] status_mask,
   input  wire logic             fault_present,
   input  wire logic             gpio_out,
   output otgc_state_t           state,
   output logic                  converter_en,
   output logic                  charge_enable,
   output logic                  storage_mode,
   output logic                  gpio_in,
   output logic                  temp_sense_en
);
   // ***********************************
   // mode request
   // ***********************************
   otgc_state_t      state_q;
   otgc_state_t      state_d;
   logic [TMR_W-1:0] tmr_q;
   logic             tmr_run;
   logic             req_level;
   logic             mode_on;
   logic             storage_q;

   assign req_level = req_active_high ? lnk.reverse_power_request_n : ~lnk.reverse_power_request_n; // [R8]
   assign mode_on   = req_level & lnk.reverse_power_allow & ~lnk.high_impedance_mode & ~storage_q; // [R7]

   function automatic logic tmr_done(input logic [TMR_W-1:0] t, input int unsigned cyc);
      tmr_done = (t == TMR_W'(cyc - 1));
   endfunction

   // ***********************************
   // reverse-power state machine
   // ***********************************
   always_comb begin
      state_d = state_q;
      tmr_run = 1'b0;
      if (!mode_on) begin
         state_d = ST_OFF; // [R4]
      end else begin
         unique case (state_q)
            ST_OFF: begin
               state_d = ST_RESET;
            end
            ST_RESET: begin
               tmr_run = faults_clear; // [R19]
               if (faults_clear && tmr_done(tmr_q, EN_DLY_CYC[reverse_start_delay_sel])) begin
                  state_d = ST_SOFTSTART; // [R19]
               end
            end
            ST_SOFTSTART: begin
               if (major_fault) begin
                  state_d = ST_RESET;
               end else if (softstart_done) begin
                  state_d = ST_REGULATE;
               end
            end
            ST_REGULATE: begin
               if (major_fault) begin
                  state_d = ST_RESET;
               end else if (out_uv) begin
                  state_d = ST_OVERLOAD_RETRY; // [R5]
               end else begin
                  // boost and buck-boost never start the timer
                  tmr_run = light_load & buck_mode; // [R2] [R21]
                  if (tmr_run && tmr_done(tmr_q, LL_DLY_CYC[light_load_delay_sel])) begin
                     state_d = ST_LIGHT_LOAD_OFF; // [R1] [R20]
                  end
               end
            end
            ST_LIGHT_LOAD_OFF: begin
               state_d = ST_LIGHT_LOAD_OFF; // [R4]
            end
            ST_OVERLOAD_RETRY: begin
               tmr_run = 1'b1;
               if (tmr_done(tmr_q, HICCUP_CYC)) begin
                  state_d = ST_RESET; // [R6]
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_q <= ST_OFF;
      end else begin
         state_q <= state_d;
      end
   end

   // one timer serves the reset, regulate and retry states; any transition restarts it
   always_ff @(posedge clk) begin
      if (sys_rst || state_d != state_q || !tmr_run) begin
         tmr_q <= '0; // [R21] [R22]
      end else begin
         tmr_q <= tmr_q + TMR_W'(1); // [R22]
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         converter_en <= 1'b0;
      end else begin
         // registered from next state so the enable tracks the state flop
         converter_en <= (state_d == ST_SOFTSTART) || (state_d == ST_REGULATE); // [R3] [R5]
      end
   end

   assign state = state_q;

   // ***********************************
   // charge pins
   // ***********************************
   logic [TMR_W-1:0] blink_cnt_q;
   logic             blink_q;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         charge_enable <= 1'b0;
      end else begin
         charge_enable <= lnk.charge_request; // [R9]
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst || !charge_fault) begin
         blink_cnt_q <= '0;
         blink_q     <= 1'b0;
      end else if (tmr_done(blink_cnt_q, BLINK_CYC)) begin
         blink_cnt_q <= '0;
         blink_q     <= ~blink_q; // [R11]
      end else begin
         blink_cnt_q <= blink_cnt_q + TMR_W'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         lnk.charge_status_oe_n <= 1'b1;
      end else if (charge_fault) begin
         lnk.charge_status_oe_n <= ~blink_q; // [R11]
      end else begin
         lnk.charge_status_oe_n <= ~charging; // [R10]
      end
   end

   // ***********************************
   // alert
   // ***********************************
   logic [NSTAT-1:0] status_prev_q;
   logic             change;

   assign change = |((status ^ status_prev_q) & ~status_mask); // [R12] [R13]

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         status_prev_q <= '0;
      end else begin
         status_prev_q <= status;
      end
   end

   // a new change in the read cycle wins over the clear; pin comes straight from this flop
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         lnk.alert_oe_n <= 1'b1;
      end else if (change) begin
         lnk.alert_oe_n <= 1'b0; // [R12]
      end else if (lnk.status_read && !fault_present) begin
         lnk.alert_oe_n <= 1'b1; // [R14] [R15]
      end
   end

   // ***********************************
   // storage exit, gpio, thermistor
   // ***********************************
   logic [TMR_W-1:0] exit_cnt_q;

   always_ff @(posedge clk) begin
      if (sys_rst || lnk.storage_exit_n || !storage_q) begin
         exit_cnt_q <= '0;
      end else begin
         exit_cnt_q <= exit_cnt_q + TMR_W'(1); // [R16]
      end
   end

   // power-up lands in storage mode
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         storage_q <= 1'b1;
      end else if (!lnk.storage_exit_n && tmr_done(exit_cnt_q, EXIT_CYC)) begin
         storage_q <= 1'b0; // [R16]
      end
   end

   assign storage_mode = storage_q;

   // gpio drive drops whenever reverse power is in use: the pin is compensation then
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         lnk.gpio_oe_n <= 1'b1;
         lnk.gpio_o    <= 1'b0;
         gpio_in       <= 1'b0;
         temp_sense_en <= 1'b0;
      end else begin
         lnk.gpio_oe_n <= ~(lnk.gpio_sel & ~mode_on); // [R17]
         lnk.gpio_o    <= gpio_out;
         gpio_in       <= lnk.comp_or_gpio_pin;
         temp_sense_en <= ~lnk.thermistor_ignore; // [R18]
      end
   end
endmodule

//--- rtl/otgc_host.sv
`timescale 1ns/1ps
module otgc_host
   import otgc_pkg::*;
#(
   parameter int unsigned EXIT_CYC = EXIT_CYC_DEF
) (
   input  wire logic              clk,
   input  wire logic              sys_rst,
   otgc_link_if.host              lnk,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [DATA_W-1:0] wdata,
   input  wire logic              we,
   input  wire logic              re,
   output logic      [DATA_W-1:0] rdata
);
   // ***********************************
   // registers
   // ***********************************
   logic [DATA_W-1:0] ctrl_q;
   logic [TMR_W-1:0]  exit_cnt_q;
   logic              exit_busy_q;
   logic              seen_q;
   logic              alert_prev_q;
   logic              alert_fall;
   logic              rd_cmd;

   assign alert_fall = alert_prev_q & ~lnk.alert_n;
   assign rd_cmd     = we && addr == OFS_CMD && wdata[CMD_READ];

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl_q <= CTRL_RESET;
      end else if (we && addr == OFS_CTRL) begin
         ctrl_q <= wdata;
      end
   end

   // pins follow control bits; request pin idles high, active low
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         lnk.reverse_power_request_n <= 1'b1;
         lnk.charge_request          <= 1'b0;
         lnk.reverse_power_allow     <= 1'b0;
         lnk.high_impedance_mode     <= 1'b0;
         lnk.thermistor_ignore       <= 1'b0;
         lnk.gpio_sel                <= 1'b0;
      end else begin
         lnk.reverse_power_request_n <= ~ctrl_q[CTRL_REQ]; // [R7]
         lnk.charge_request          <= ctrl_q[CTRL_CHG]; // [R9]
         lnk.reverse_power_allow     <= ctrl_q[CTRL_ALLOW]; // [R7]
         lnk.high_impedance_mode     <= ctrl_q[CTRL_HIZ];
         lnk.thermistor_ignore       <= ctrl_q[CTRL_THIGN]; // [R18]
         lnk.gpio_sel                <= ctrl_q[CTRL_GPIO];
      end
   end

   // ***********************************
   // storage exit pulse
   // ***********************************
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         exit_busy_q        <= 1'b0;
         exit_cnt_q         <= '0;
         lnk.storage_exit_n <= 1'b1;
      end else if (exit_busy_q) begin
         // holds one cycle past the device's count for margin
         if (exit_cnt_q == TMR_W'(EXIT_CYC)) begin
            exit_busy_q        <= 1'b0;
            lnk.storage_exit_n <= 1'b1;
         end else begin
            exit_cnt_q <= exit_cnt_q + TMR_W'(1); // [R16]
         end
      end else if (we && addr == OFS_CMD && wdata[CMD_EXIT]) begin
         exit_busy_q        <= 1'b1;
         exit_cnt_q         <= '0;
         lnk.storage_exit_n <= 1'b0; // [R16]
      end
   end

   // ***********************************
   // alert service
   // ***********************************
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         alert_prev_q    <= 1'b1;
         lnk.status_read <= 1'b0;
      end else begin
         alert_prev_q    <= lnk.alert_n;
         lnk.status_read <= alert_fall | rd_cmd; // [R14]
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         seen_q <= 1'b0;
      end else if (alert_fall) begin
         seen_q <= 1'b1;
      end else if (we && addr == OFS_STATUS && wdata[ST_SEEN]) begin
         seen_q <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rdata <= '0;
      end else if (re) begin
         unique case (addr)
            OFS_CTRL:   rdata <= ctrl_q;
            OFS_STATUS: rdata <= {3'h0, lnk.alert_n, lnk.comp_or_gpio_pin, lnk.charge_status_n, seen_q, exit_busy_q};
            default:    rdata <= '0;
         endcase
      end else begin
         rdata <= '0;
      end
   end
endmodule

//--- testbench/otgc_sva.sv
`timescale 1ns/1ps
// ****************
// link checker
// ****************
module otgc_sva
   import otgc_pkg::*;
#(
   parameter int unsigned HICCUP_CYC = 50,
   parameter int unsigned EXIT_CYC   = 20
) (
   input wire logic        clk,
   input wire logic        sys_rst,
   input wire logic        alert_oe_n,
   input wire logic        status_read,
   input wire logic        gpio_sel,
   input wire logic        gpio_oe_n,
   input wire logic        storage_exit_n,
   input wire logic        reverse_power_allow,
   input wire otgc_state_t state,
   input wire logic        converter_en,
   input wire logic        storage_mode,
   input wire logic        buck_mode
);
   int unsigned retry_cnt_q;
   int unsigned low_cnt_q;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   // counts samples spent in retry, so the off time is checked to the cycle
   always_ff @(posedge clk) begin
      if (sys_rst || state != ST_OVERLOAD_RETRY) begin
         retry_cnt_q <= 0;
      end else begin
         retry_cnt_q <= retry_cnt_q + 1;
      end
   end
   always_ff @(posedge clk) begin
      if (sys_rst || storage_exit_n) begin
         low_cnt_q <= 0;
      end else begin
         low_cnt_q <= low_cnt_q + 1;
      end
   end

   alert_hold_a: assert property (!alert_oe_n && !status_read |=> !alert_oe_n)
      else $error("alert released without a status read");
   alert_release_a: assert property ($rose(alert_oe_n) |-> $past(status_read) || $past(sys_rst))
      else $error("alert released with no read before it");
   read_pulse_a: assert property (status_read |=> !status_read)
      else $error("status read longer than one cycle");
   gpio_drive_a: assert property (!gpio_oe_n |-> $past(gpio_sel))
      else $error("pin driven without gpio select");
   light_quiet_a: assert property (state == ST_LIGHT_LOAD_OFF |-> !converter_en)
      else $error("converter on in light-load off");
   light_exit_a: assert property (state == ST_LIGHT_LOAD_OFF |=> state inside {ST_LIGHT_LOAD_OFF, ST_OFF})
      else $error("light-load off left while mode on");
   light_entry_a: assert property (state == ST_LIGHT_LOAD_OFF && $past(state) != ST_LIGHT_LOAD_OFF |->
      $past(state) == ST_REGULATE && $past(buck_mode)) else $error("bad light-load entry");
   retry_hold_a: assert property (state == ST_OVERLOAD_RETRY |->
      retry_cnt_q < HICCUP_CYC && !converter_en) else $error("retry too long or converter on");
   retry_end_a: assert property ($past(state) == ST_OVERLOAD_RETRY && state != ST_OVERLOAD_RETRY |->
      state == ST_OFF || state == ST_RESET && retry_cnt_q == HICCUP_CYC) else $error("bad retry end");
   storage_exit_a: assert property ($fell(storage_mode) |-> low_cnt_q == EXIT_CYC)
      else $error("storage left after wrong hold");
   storage_stay_a: assert property (!storage_mode |=> !storage_mode)
      else $error("storage mode re-entered");
   start_allow_a: assert property ($past(state) == ST_OFF && state != ST_OFF |-> $past(reverse_power_allow))
      else $error("reverse power started without allow");
endmodule

//--- testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top
   import otgc_pkg::*;
;
   localparam int unsigned HIC = 50;
   localparam int unsigned EXC = 20;
   logic              clk, sys_rst, we, re;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata, rdata;
   logic              req_active_high, light_load, buck_mode, out_uv, faults_clear, softstart_done;
   logic              major_fault, charging, charge_fault, fault_present, gpio_out;
   logic [1:0]        light_load_delay_sel, reverse_start_delay_sel;
   logic [7:0]        status, status_mask;
   otgc_state_t       state;
   logic              converter_en, charge_enable, storage_mode, gpio_in, temp_sense_en;
   int                num_errors, check_count, cyc, lows;

   otgc_link_if link();
   otgc_host #(.EXIT_CYC(EXC)) otgc_host_inst (.clk(clk), .sys_rst(sys_rst), .lnk(link), .addr(addr),
      .wdata(wdata), .we(we), .re(re), .rdata(rdata));
   otgc_device #(.HICCUP_CYC(HIC), .BLINK_CYC(8), .EXIT_CYC(EXC), .LL_DLY_CYC('{3, 4, 5, 6}),
      .EN_DLY_CYC('{3, 4, 5, 6}), .NSTAT(8)) otgc_device_inst (.clk(clk), .sys_rst(sys_rst), .lnk(link),
      .req_active_high(req_active_high), .light_load_delay_sel(light_load_delay_sel),
      .reverse_start_delay_sel(reverse_start_delay_sel), .light_load(light_load), .buck_mode(buck_mode),
      .out_uv(out_uv), .faults_clear(faults_clear), .softstart_done(softstart_done), .major_fault(major_fault),
      .charging(charging), .charge_fault(charge_fault), .status(status), .status_mask(status_mask),
      .fault_present(fault_present), .gpio_out(gpio_out), .state(state), .converter_en(converter_en),
      .charge_enable(charge_enable), .storage_mode(storage_mode), .gpio_in(gpio_in),
      .temp_sense_en(temp_sense_en));
   otgc_sva #(.HICCUP_CYC(HIC), .EXIT_CYC(EXC)) otgc_sva_inst (.clk(clk), .sys_rst(sys_rst),
      .alert_oe_n(link.alert_oe_n), .status_read(link.status_read), .gpio_sel(link.gpio_sel),
      .gpio_oe_n(link.gpio_oe_n), .storage_exit_n(link.storage_exit_n),
      .reverse_power_allow(link.reverse_power_allow), .state(state), .converter_en(converter_en),
      .storage_mode(storage_mode), .buck_mode(buck_mode));

   // ****************
   // helpers
   // ****************
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      we <= 1'b1;
      @(posedge clk);
      we <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      re <= 1'b1;
      @(posedge clk);
      re <= 1'b0;
      #1;
      chk(rdata, exp);
   endtask
   // bounded wait, then the state itself is compared
   task automatic wst(input otgc_state_t s, input int n);
      #1;
      for (int i = 0; i < n && state !== s; i++) begin
         @(posedge clk);
         #1;
      end
      chk({5'h00, state}, {5'h00, s});
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // ceiling well above the few hundred cycles the sequence needs
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         num_errors++;
         tally_and_finish;
      end
   end

   initial begin
      {sys_rst, we, re, addr, wdata} = {1'b1, 14'h0000};
      {req_active_high, light_load, buck_mode, out_uv, faults_clear, major_fault} = 6'h00;
      {charging, charge_fault, fault_present, gpio_out, status, status_mask} = 20'h00000;
      {light_load_delay_sel, reverse_start_delay_sel, softstart_done} = 5'h01;
      {num_errors, check_count, cyc} = 0;
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      rd(OFS_CTRL, CTRL_RESET);
      rd(OFS_STATUS, 8'h1c);
      wr(4'h7, 8'hff);
      rd(4'hf, 8'h00);
      rd(OFS_CTRL, 8'h00);
      chk({7'h00, storage_mode}, 8'h01);
      $display("test reset done");
      wr(OFS_CTRL, 8'h05);
      wt(8);
      chk({5'h00, state}, {5'h00, ST_OFF});
      wr(OFS_CMD, 8'h01);
      wt(EXC + 4);
      chk({7'h00, storage_mode}, 8'h00);
      wst(ST_RESET, 6);
      wt(10);
      chk({5'h00, state}, {5'h00, ST_RESET});
      @(posedge clk) faults_clear <= 1'b1;
      wst(ST_REGULATE, 12);
      chk({7'h00, converter_en}, 8'h01);
      $display("test start done");
      @(posedge clk) light_load <= 1'b1;
      wt(12);
      chk({5'h00, state}, {5'h00, ST_REGULATE});
      @(posedge clk) buck_mode <= 1'b1;
      // two-cycle bursts never reach the three-cycle delay
      repeat (6) begin
         @(posedge clk) light_load <= 1'b0;
         @(posedge clk) light_load <= 1'b1;
         @(posedge clk);
      end
      #1;
      chk({5'h00, state}, {5'h00, ST_REGULATE});
      wst(ST_LIGHT_LOAD_OFF, 8);
      chk({7'h00, converter_en}, 8'h00);
      @(posedge clk) light_load <= 1'b0;
      wt(6);
      chk({5'h00, state}, {5'h00, ST_LIGHT_LOAD_OFF});
      wr(OFS_CTRL, 8'h0d);
      wst(ST_OFF, 6);
      wr(OFS_CTRL, 8'h01);
      wt(10);
      chk({5'h00, state}, {5'h00, ST_OFF});
      wr(OFS_CTRL, 8'h05);
      wst(ST_REGULATE, 24);
      $display("test light load done");
      @(posedge clk) out_uv <= 1'b1;
      wst(ST_OVERLOAD_RETRY, 4);
      wst(ST_RESET, HIC + 4);
      wst(ST_OVERLOAD_RETRY, 24);
      @(posedge clk) out_uv <= 1'b0;
      wst(ST_REGULATE, HIC + 24);
      @(posedge clk) req_active_high <= 1'b1;
      wr(OFS_CTRL, 8'h04);
      wst(ST_REGULATE, 24);
      wr(OFS_CTRL, 8'h05);
      wst(ST_OFF, 6);
      @(posedge clk) req_active_high <= 1'b0;
      $display("test retry done");
      wr(OFS_CTRL, 8'h02);
      wt(3);
      chk({7'h00, charge_enable}, 8'h01);
      @(posedge clk) charging <= 1'b1;
      wt(3);
      chk({7'h00, link.charge_status_n}, 8'h00);
      @(posedge clk) charging <= 1'b0;
      wt(3);
      chk({7'h00, link.charge_status_n}, 8'h01);
      @(posedge clk) charge_fault <= 1'b1;
      wt(20);
      lows = 0;
      repeat (16) begin
         wt(1);
         if (link.charge_status_n === 1'b0) lows++;
      end
      chk(lows[7:0], 8'h08);
      @(posedge clk) charge_fault <= 1'b0;
      wr(OFS_CTRL, 8'h00);
      wt(3);
      chk({7'h00, charge_enable}, 8'h00);
      $display("test charge done");
      @(posedge clk) fault_present <= 1'b1;
      @(posedge clk) status <= 8'h01;
      wt(10);
      chk({7'h00, link.alert_n}, 8'h00);
      rd(OFS_STATUS, 8'h0e);
      @(posedge clk) fault_present <= 1'b0;
      wr(OFS_CMD, 8'h02);
      wt(3);
      chk({7'h00, link.alert_n}, 8'h01);
      wr(OFS_STATUS, 8'h02);
      @(posedge clk) status_mask <= 8'h80;
      @(posedge clk) status <= 8'h81;
      wt(8);
      rd(OFS_STATUS, 8'h1c);
      @(posedge clk) status <= 8'h80;
      wt(10);
      rd(OFS_STATUS, 8'h1e);
      chk({7'h00, link.alert_n}, 8'h01);
      $display("test alert done");
      wr(OFS_CTRL, 8'h20);
      wt(4);
      chk({6'h00, gpio_in, link.comp_or_gpio_pin}, 8'h00);
      @(posedge clk) gpio_out <= 1'b1;
      wt(3);
      chk({6'h00, gpio_in, link.comp_or_gpio_pin}, 8'h03);
      @(posedge clk) gpio_out <= 1'b0;
      wr(OFS_CTRL, 8'h25);
      wt(6);
      chk({7'h00, link.comp_or_gpio_pin}, 8'h01);
      wr(OFS_CTRL, 8'h10);
      wt(3);
      chk({7'h00, temp_sense_en}, 8'h00);
      @(posedge clk) sys_rst <= 1'b1;
      wt(3);
      @(posedge clk) sys_rst <= 1'b0;
      wt(1);
      chk({4'h0, storage_mode, state}, {4'h0, 1'b1, ST_OFF});
      $display("test gpio and reset done");
      tally_and_finish;
   end
endmodule
